// ==== logic/pcw_pkg.sv ====
// Package: addresses, field positions, reset values and state types of the PWM cycle block
package pcw_pkg;
    localparam int           NUM_CH          = 3;
    localparam logic [7:0]   ADDR_PWM_CFG    = 8'hf7;
    localparam logic [7:0]   ADDR_CLR_CTRL   = 8'hce;
    // Shared capture/compare addresses, low and high byte, channel 2..0
    localparam logic [2:0][7:0] ADDR_CMP_LOW  = {8'heb, 8'he9, 8'hfb};
    localparam logic [2:0][7:0] ADDR_CMP_HIGH = {8'hec, 8'hea, 8'hfc};
    localparam int           BIT_RELOAD_SEL  = 7;
    localparam int           BIT_OVF_IRQ_EN  = 6;
    localparam int           BIT_OVF_FLAG    = 5;
    localparam int           BIT_CLR_POL     = 7;
    localparam logic [1:0]   RST_CYC_LEN     = 2'h0;
    localparam logic [7:0]   RST_CLR_CTRL    = 8'h00;
    localparam logic [15:0]  RST_COMPARE     = 16'h0000;
    localparam logic [15:0]  RST_RELOAD      = 16'h0000;
    localparam logic [7:0]   RD_UNMAPPED     = 8'h00;
    localparam logic [15:0]  MASK_8          = 16'h00ff;
    localparam logic [15:0]  MASK_9          = 16'h01ff;
    localparam logic [15:0]  MASK_10         = 16'h03ff;
    localparam logic [15:0]  MASK_11         = 16'h07ff;
    localparam logic [15:0]  MASK_16         = 16'hffff;

    typedef struct packed {
        logic [7:0] addr;
        logic       wr;
        logic       rd;
        logic [7:0] wdata;
    } pcw_sfr_req_s;

    typedef struct packed {
        logic             reload_sel;
        logic             ovf_irq_en;
        logic             ovf_flag;
        logic [1:0]       cyc_len;
        logic [7:0]       clr_ctrl;
        logic [2:0][15:0] compare;
        logic [2:0][15:0] reload;
        logic             cmp_meta;
        logic             cmp_sync;
        logic             cmp_prev;
        logic [7:0]       rdata;
        logic             irq;
    } pcw_state_s;

    typedef struct packed {
        logic out;
        logic held;
    } pcw_ch_state_s;
endpackage : pcw_pkg

// ==== logic/pcw_channel.sv ====
// One PWM channel output with comparator clear hold
`timescale 1ns/1ps
`default_nettype none
module pcw_channel (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        pwm_enable,
    input  wire logic [15:0] cycle_mask,
    input  wire logic [15:0] counter_value,
    input  wire logic [15:0] compare_value,
    input  wire logic        cycle_start,
    input  wire logic        clear_pulse,
    output var  logic        channel_output
);
    pcw_pkg::pcw_ch_state_s q;
    pcw_pkg::pcw_ch_state_s d;

    always_comb begin
        d = q;
        if (clear_pulse) begin
            d.held = 1'b1; // R12
        end else if (cycle_start) begin
            d.held = 1'b0; // R12
        end
        d.out = pwm_enable & ~d.held &
                ((counter_value & cycle_mask) < (compare_value & cycle_mask)); // R12
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign channel_output = q.out;
endmodule // pcw_channel
`default_nettype wire

// ==== logic/pcw_top.sv ====
// Counter-array PWM cycle configuration and comparator clear control
//
// Operation
// R1: Reload-select 0 maps shared addresses to compare registers, 1 to auto-reload registers.
// R2: Auto-reload values load only in 9, 10 and 11 bit modes.
// R3: Interrupt raised while overflow flag set and its enable is set.
// R4: Overflow flag sets when counter wraps at the selected 8 to 11 bit.
// R5: Flag set by hardware or software write of 1; only software clears.
// R6: Configuration bits 4 to 2 read zero, writes ignored.
// R7: Cycle-length select 00..11 gives 8..11 bit cycles for narrow channels.
// R8: A 16-bit channel ignores cycle-length select, runs full 16-bit cycle.
// R9: Clear polarity 0 clears on falling comparator, 1 on rising.
// R10: Clear-enable bits 0..2 each enable clear for channel 0..2.
// R11: Wide select set gives 16-bit PWM, clear gives 8 to 11 bit.
// R12: Clear forces output inactive until next PWM cycle starts.
// R13: Comparator synchronised before edge detect; one clear per transition.
`timescale 1ns/1ps
`default_nettype none
module pcw_top #(
    parameter int NUM_CH = pcw_pkg::NUM_CH
) (
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire pcw_pkg::pcw_sfr_req_s sfr_req,
    output var  logic [7:0]           sfr_rdata,
    input  wire logic [15:0]          counter_value,
    input  wire logic                 counter_tick,
    input  wire logic [2:0]           channel_pwm_enable,
    input  wire logic [2:0]           wide_pwm_select,
    input  wire logic                 comparator_in,
    output var  logic                 cycle_overflow_irq,
    output var  logic [2:0]           channel_output
);
    pcw_pkg::pcw_state_s q;
    pcw_pkg::pcw_state_s d;
    logic [15:0]       narrow_mask;
    logic [2:0][15:0]  ch_mask;
    logic [2:0]        ch_wrap;
    logic [2:0]        ch_clear;
    logic              narrow_wrap;
    logic              clr_event;
    logic              cfg_hit;
    logic              clr_hit;
    logic [2:0]        low_hit;
    logic [2:0]        high_hit;
    logic [7:0]        cfg_word;

    // Cycle length of narrow channels
    always_comb begin
        case (q.cyc_len)
            2'h0:    narrow_mask = pcw_pkg::MASK_8;  // R7
            2'h1:    narrow_mask = pcw_pkg::MASK_9;  // R7
            2'h2:    narrow_mask = pcw_pkg::MASK_10; // R7
            2'h3:    narrow_mask = pcw_pkg::MASK_11; // R7
            default: narrow_mask = pcw_pkg::MASK_8;
        endcase
    end

    // Cycle overflow at the selected narrow length
    always_comb begin
        narrow_wrap = 1'b0;
        if (counter_tick && ((counter_value & narrow_mask) == narrow_mask)) begin
            narrow_wrap = 1'b1; // R4
        end
    end

    // Comparator edge of the selected polarity
    always_comb begin
        if (q.clr_ctrl[pcw_pkg::BIT_CLR_POL]) begin
            clr_event = q.cmp_sync & ~q.cmp_prev; // R9 R13
        end else begin
            clr_event = ~q.cmp_sync & q.cmp_prev; // R9 R13
        end
    end

    // Address decode
    always_comb begin
        cfg_hit  = (sfr_req.addr == pcw_pkg::ADDR_PWM_CFG);
        clr_hit  = (sfr_req.addr == pcw_pkg::ADDR_CLR_CTRL);
        low_hit  = '0;
        high_hit = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            low_hit[i]  = (sfr_req.addr == pcw_pkg::ADDR_CMP_LOW[i]);
            high_hit[i] = (sfr_req.addr == pcw_pkg::ADDR_CMP_HIGH[i]);
        end
    end

    // Configuration readback, unused bits forced to zero
    always_comb begin
        cfg_word                          = 8'h00; // R6
        cfg_word[pcw_pkg::BIT_RELOAD_SEL] = q.reload_sel;
        cfg_word[pcw_pkg::BIT_OVF_IRQ_EN] = q.ovf_irq_en;
        cfg_word[pcw_pkg::BIT_OVF_FLAG]   = q.ovf_flag;
        cfg_word[1:0]                     = q.cyc_len;
    end

    always_comb begin
        d = q;
        ch_mask  = '0;
        ch_wrap  = '0;
        ch_clear = '0;
        // Comparator synchroniser and edge history
        d.cmp_meta = comparator_in;  // R13
        d.cmp_sync = q.cmp_meta;     // R13
        d.cmp_prev = q.cmp_sync;     // R13
        // Per-channel mask, wrap and clear
        for (int i = 0; i < NUM_CH; i++) begin
            ch_mask[i]  = wide_pwm_select[i] ? pcw_pkg::MASK_16 : narrow_mask; // R8 R11
            ch_wrap[i]  = counter_tick && ((counter_value & ch_mask[i]) == ch_mask[i]);
            ch_clear[i] = clr_event & q.clr_ctrl[i]; // R10
            // Reload of narrow channels at their cycle wrap
            if (ch_wrap[i] && !wide_pwm_select[i]) begin
                if (q.cyc_len != 2'h0) begin
                    d.compare[i][10:0] = q.reload[i][10:0]; // R2
                end else begin
                    d.compare[i][7:0] = q.compare[i][15:8];
                end
            end
        end
        // Register writes
        if (sfr_req.wr) begin
            // Unused bits 4 to 2 are not stored
            if (cfg_hit) begin
                d.reload_sel = sfr_req.wdata[pcw_pkg::BIT_RELOAD_SEL];
                d.ovf_irq_en = sfr_req.wdata[pcw_pkg::BIT_OVF_IRQ_EN];
                d.ovf_flag   = sfr_req.wdata[pcw_pkg::BIT_OVF_FLAG]; // R5
                d.cyc_len    = sfr_req.wdata[1:0]; // R6
            end
            if (clr_hit) begin
                d.clr_ctrl = sfr_req.wdata;
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (low_hit[i]) begin
                    if (q.reload_sel) begin
                        d.reload[i][7:0] = sfr_req.wdata; // R1
                    end else begin
                        d.compare[i][7:0] = sfr_req.wdata; // R1
                    end
                end
                if (high_hit[i]) begin
                    if (q.reload_sel) begin
                        d.reload[i][15:8] = sfr_req.wdata; // R1
                    end else begin
                        d.compare[i][15:8] = sfr_req.wdata; // R1
                    end
                end
            end
        end
        // Hardware set wins over a software clear
        if (narrow_wrap) begin
            d.ovf_flag = 1'b1; // R4 R5
        end
        // Register reads
        if (sfr_req.rd) begin
            d.rdata = pcw_pkg::RD_UNMAPPED;
            if (cfg_hit) begin
                d.rdata = cfg_word; // R6
            end
            if (clr_hit) begin
                d.rdata = q.clr_ctrl;
            end
            for (int i = 0; i < NUM_CH; i++) begin
                if (low_hit[i]) begin
                    if (q.reload_sel) begin
                        d.rdata = q.reload[i][7:0]; // R1
                    end else begin
                        d.rdata = q.compare[i][7:0]; // R1
                    end
                end
                if (high_hit[i]) begin
                    if (q.reload_sel) begin
                        d.rdata = q.reload[i][15:8]; // R1
                    end else begin
                        d.rdata = q.compare[i][15:8]; // R1
                    end
                end
            end
        end
        d.irq = q.ovf_irq_en & q.ovf_flag; // R3
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            q.reload_sel <= 1'b0;
            q.ovf_irq_en <= 1'b0;
            q.ovf_flag   <= 1'b0;
            q.cmp_meta   <= 1'b0;
            q.cmp_sync   <= 1'b0;
            q.cmp_prev   <= 1'b0;
            q.irq        <= 1'b0;
            q.cyc_len  <= pcw_pkg::RST_CYC_LEN;
            q.clr_ctrl <= pcw_pkg::RST_CLR_CTRL;
            q.compare  <= {3{pcw_pkg::RST_COMPARE}};
            q.reload   <= {3{pcw_pkg::RST_RELOAD}};
            q.rdata    <= pcw_pkg::RD_UNMAPPED;
        end else begin
            q <= d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            pcw_channel u_ch (
                .clk_sys        (clk_sys),
                .reset          (reset),
                .pwm_enable     (channel_pwm_enable[g]),
                .cycle_mask     (ch_mask[g]),
                .counter_value  (counter_value),
                .compare_value  (q.compare[g]),
                .cycle_start    (ch_wrap[g]),
                .clear_pulse    (ch_clear[g]),
                .channel_output (channel_output[g])
            );
        end
    endgenerate

    assign sfr_rdata          = q.rdata;
    assign cycle_overflow_irq = q.irq;
endmodule // pcw_top
`default_nettype wire

// ==== testbench/pcw_properties.sv ====
// Port checker for the PWM cycle block
`timescale 1ns/1ps
`default_nettype none
module pcw_properties (
    input wire logic                  clk_sys,
    input wire logic                  reset,
    input wire pcw_pkg::pcw_sfr_req_s sfr_req,
    input wire logic [7:0]            sfr_rdata,
    input wire logic [15:0]           counter_value,
    input wire logic                  counter_tick,
    input wire logic [2:0]            channel_pwm_enable,
    input wire logic                  cycle_overflow_irq,
    input wire logic [2:0]            channel_output
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);
    wire logic cw = sfr_req.wr && sfr_req.addr == 8'hf7;
    wire logic rc = sfr_req.rd && sfr_req.addr == 8'hf7;
    wire logic lw = sfr_req.wr && sfr_req.addr == 8'hce;
    wire logic lr = sfr_req.rd && sfr_req.addr == 8'hce;
    sequence s_ovf; counter_tick && counter_value[10:0] == 11'h7ff ##1 rc; endsequence
    sequence s_cfg; cw ##1 rc; endsequence
    sequence s_clr; lw ##1 lr; endsequence
    property p_rsv; rc |=> sfr_rdata[4:2] == 3'h0; endproperty
    property p_irq_off; cw && !sfr_req.wdata[6] |=> ##1 !cycle_overflow_irq; endproperty
    property p_irq_on; cw && sfr_req.wdata[6:5] == 2'h3 |=> ##1 cycle_overflow_irq; endproperty
    property p_hold; cycle_overflow_irq && !$past(cw) |=> cycle_overflow_irq; endproperty
    property p_ovf; s_ovf |=> sfr_rdata[5]; endproperty
    property p_cfg; s_cfg |=> sfr_rdata[7:6] == $past(sfr_req.wdata[7:6], 2)
        && sfr_rdata[1:0] == $past(sfr_req.wdata[1:0], 2); endproperty
    property p_clr; s_clr |=> sfr_rdata == $past(sfr_req.wdata, 2); endproperty
    property p_off; channel_pwm_enable == 3'h0 |=> channel_output == 3'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    a_irq_on: assert property (p_irq_on) else $error("irq missing");
    a_hold: assert property (p_hold) else $error("flag cleared by hardware");
    a_ovf: assert property (p_ovf) else $error("overflow flag not set");
    a_cfg: assert property (p_cfg) else $error("config readback wrong");
    a_clr: assert property (p_clr) else $error("clear control readback wrong");
    a_off: assert property (p_off) else $error("disabled channel active");
endmodule // pcw_properties
bind pcw_top pcw_properties pcw_properties_i (.clk_sys(clk_sys), .reset(reset), .sfr_req(sfr_req),
    .sfr_rdata(sfr_rdata), .counter_value(counter_value), .counter_tick(counter_tick),
    .channel_pwm_enable(channel_pwm_enable), .cycle_overflow_irq(cycle_overflow_irq),
    .channel_output(channel_output));
`default_nettype wire

// ==== testbench/pcw_top_tb.sv ====
// Self-checking bench of the PWM cycle block
`timescale 1ns/1ps
`default_nettype none
module pcw_top_tb;
    logic                  clk_sys, reset, cmp_in, tick, irq;
    pcw_pkg::pcw_sfr_req_s req;
    logic [7:0]            rdata, cfg, mv[12];
    logic [7:0]            ad[6] = '{8'hfb, 8'hfc, 8'he9, 8'hea, 8'heb, 8'hec};
    logic [15:0]           cnt, lf, m;
    logic [2:0]            en, wide, out;
    int                    fails, cmp_count, i, j;
    pcw_top pcw_top_i (.clk_sys(clk_sys), .reset(reset), .sfr_req(req), .sfr_rdata(rdata), .counter_value(cnt),
        .counter_tick(tick), .channel_pwm_enable(en), .wide_pwm_select(wide), .comparator_in(cmp_in),
        .cycle_overflow_irq(irq), .channel_output(out));
    function automatic logic [15:0] nx(logic [15:0] x); return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]}; endfunction
    task automatic cyc(int n); repeat (n) @(posedge clk_sys); #1; endtask
    task automatic chk(logic [15:0] g, logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            $display("ERROR t=%0t got %h exp %h", $time, g, e);
            fails++;
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d); req = {a, 2'b10, d}; cyc(1); req = '0; endtask
    task automatic rd(logic [7:0] a, logic [7:0] e); req = {a, 2'b01, 8'h00}; cyc(1); req = '0; cyc(1); chk(rdata, e); endtask
    task automatic wc(logic [7:0] d); cfg = d & 8'he3; wr(8'hf7, d); endtask
    task automatic tk(logic [15:0] v); cnt = v; tick = 1; cyc(1); tick = 0; endtask
    task automatic complete_run;
        $display("fails=%0d compares=%0d", fails, cmp_count);
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        clk_sys = 0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        #100000;
        fails++;
        complete_run;
    end
    initial begin
        reset = 1; req = '0; cnt = 0; tick = 0; en = 0; wide = 0; cmp_in = 0; fails = 0; cmp_count = 0; lf = 16'hb295;
        cyc(4);
        reset = 0;
        rd(8'hf7, 8'h00);
        rd(8'hce, 8'h00);
        wc(8'hff); rd(8'hf7, cfg);
        chk(irq, 1);
        wc(8'h20); rd(8'hf7, cfg);
        chk(irq, 0);
        wc(8'h40); rd(8'hf7, cfg);
        for (i = 0; i < 4; i++) begin
            m = 16'((1 << (8 + i)) - 1);
            wc(8'h40 | i[7:0]); tk(m >> 1); rd(8'hf7, cfg);
            tk(m); rd(8'hf7, cfg | 8'h20);
            chk(irq, 1);
        end
        for (i = 0; i < 12; i++) begin
            if (i % 6 == 0) wc(8'(i / 6) << 7);
            mv[i] = lf[7:0]; lf = nx(lf); wr(ad[i % 6], mv[i]);
        end
        for (i = 0; i < 12; i++) begin
            if (i % 6 == 0) wc(8'(i / 6) << 7);
            rd(ad[i % 6], mv[i]);
        end
        wr(8'hce, lf[7:0]); rd(8'hce, lf[7:0]);
        wc(8'h00);
        for (j = 0; j < 6; j++) wr(ad[j], 8'h80);
        en = 3'h7; cnt = 16'h0010; cyc(2); chk(out, 3'h7);
        wide = 3'h1; cnt = 16'h8110; cyc(2); chk(out, 3'h6);
        wide = 3'h0; cnt = 16'h0010;
        wr(8'hce, 8'h05); cmp_in = 1; cyc(6); chk(out, 3'h7);
        cmp_in = 0; cyc(6); chk(out, 3'h2);
        tk(16'h00ff); cnt = 16'h0010; cyc(2); chk(out, 3'h7);
        wr(8'hce, 8'h82); cmp_in = 1; cyc(6); chk(out, 3'h5);
        en = 3'h0; cyc(2); chk(out, 3'h0);
        complete_run;
    end
endmodule // pcw_top_tb
`default_nettype wire
